// File: hw/eccp_pkg.sv
// Constants, register map and encodings for the enhanced capture/compare/PWM control block
`default_nettype none

package eccp_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TSEL = 8'h04;
  localparam logic [7:0] OFS_ASD = 8'h08;
  localparam logic [7:0] OFS_PWMC = 8'h0c;
  localparam logic [7:0] OFS_STEER = 8'h10;
  localparam logic [7:0] OFS_DUTY = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_TSEL = 8'h00;
  localparam logic [7:0] RST_ASD = 8'h00;
  localparam logic [7:0] RST_PWMC = 8'h00;
  localparam logic [4:0] RST_STEER = 5'h01;
  localparam logic [7:0] RST_DUTY = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_HI = 7;
  localparam int CFG_LO = 6;
  localparam int DCB_HI = 5;
  localparam int DCB_LO = 4;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 0;
  localparam int POL_AC_BIT = 1;
  localparam int POL_BD_BIT = 0;
  localparam int ASE_BIT = 7;
  localparam int SRC_HI = 6;
  localparam int SRC_LO = 4;
  localparam int PSSAC_HI = 3;
  localparam int PSSAC_LO = 2;
  localparam int PSSBD_HI = 1;
  localparam int PSSBD_LO = 0;
  localparam int RSEN_BIT = 7;
  localparam int DLY_HI = 6;
  localparam int DLY_LO = 0;
  localparam int SYNC_BIT = 4;
  localparam int STR_HI = 3;
  localparam int STAT_IRQ_BIT = 0;
  localparam int STAT_SD_BIT = 1;

  // ****************************************
  // Mode, configuration, timer select and prescale codes
  // ****************************************
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4 = 4'h6;
  localparam logic [3:0] MODE_CAP_16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CFG_REV = 2'h3;
  localparam logic [1:0] TSEL_RESERVED = 2'h3;
  localparam logic [3:0] PRESC_4_LAST = 4'h3;
  localparam logic [3:0] PRESC_16_LAST = 4'hf;

  // ****************************************
  // Pins and instruction cycle
  // ****************************************
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;
  localparam int INSTR_CLKS = 4;
  localparam logic [1:0] Q_LAST = 2'(INSTR_CLKS - 1);

  // Shutdown sequencing, one bit per step except resume to run (11 to 00)
  typedef enum logic [1:0] {
    SD_RUN = 2'b00,
    SD_TRIP = 2'b01,
    SD_RESUME = 2'b11
  } eccp_sd_e;

endpackage : eccp_pkg

`default_nettype wire

// File: hw/eccp_ctrl_decode.sv
// Control registers and mode decode of an enhanced capture/compare/PWM unit
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module eccp_ctrl_decode
  import eccp_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DLY_W = 7
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer core, comparators and converter
  input wire logic tmr_match,
  input wire logic period_start,
  input wire logic pwm_raw,
  input wire logic cap_in,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic int_pin_n,
  input wire logic adc_enable,
  // Events and decode results
  output logic cap_pulse,
  output logic tmr_rst_pulse,
  output logic adc_start_pulse,
  output logic [9:0] duty_value,
  output logic [11:0] timer_pick,
  // Bridge pins: value, enable (low drives), handed to port
  output logic [3:0] out_pin_o,
  output logic [3:0] out_pin_oe_n,
  output logic [3:0] out_pin_port
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] ctrl;
  logic [7:0] tsel;
  logic [6:0] asd;
  logic shutdown_status;
  logic [7:0] pwmc;
  logic [4:0] steer;
  logic [7:0] duty_high_byte;
  logic unit_irq_flag;
  logic [3:0] steer_eff;
  eccp_sd_e sd_state;
  logic [1:0] q_cnt;
  logic cmp_pin;
  logic cap_prev;
  logic [3:0] presc;

  // Field views
  logic [3:0] mode_select;
  logic [1:0] output_config;
  logic is_pwm;
  logic pol_ac;
  logic pol_bd;
  logic [2:0] shutdown_source;
  logic auto_restart_enable;
  logic [DLY_W-1:0] dead_delay_count;
  logic instr_edge;
  logic src_hit;
  logic sd_on;

  assign mode_select = ctrl[MODE_HI:MODE_LO];
  assign output_config = ctrl[CFG_HI:CFG_LO];
  assign is_pwm = (mode_select[3:2] == MODE_PWM_TOP);
  assign pol_ac = mode_select[POL_AC_BIT];
  assign pol_bd = mode_select[POL_BD_BIT];
  assign shutdown_source = asd[SRC_HI:SRC_LO];
  assign auto_restart_enable = pwmc[RSEN_BIT];
  assign dead_delay_count = pwmc[DLY_HI:DLY_LO];
  assign instr_edge = (q_cnt == Q_LAST);
  assign sd_on = (sd_state != SD_RUN);

  // ****************************************
  // APB slave
  // ****************************************
  logic acc;
  logic wr_en;
  logic w1c_irq;
  logic hit;
  logic [31:0] rd_word;

  assign acc = psel && penable && pready;
  assign wr_en = acc && pwrite;
  assign w1c_irq = wr_en && (paddr[7:0] == OFS_STAT) && pwdata[STAT_IRQ_BIT];

  // Read mux and address decode
  always_comb begin
    rd_word = 32'h0000_0000;
    hit = 1'b1;
    unique case (paddr[7:0])
      OFS_CTRL: rd_word[7:0] = ctrl;
      OFS_TSEL: rd_word[7:0] = tsel;
      OFS_ASD: rd_word[7:0] = {shutdown_status, asd};
      OFS_PWMC: rd_word[7:0] = pwmc;
      OFS_STEER: rd_word[4:0] = steer;
      OFS_DUTY: rd_word[7:0] = duty_high_byte;
      OFS_STAT: rd_word[1:0] = {sd_on, unit_irq_flag};
      default: hit = 1'b0;
    endcase
  end

  // One wait state, then registered answer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr <= !hit;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Plain software registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= RST_CTRL;
      tsel <= RST_TSEL;
      asd <= RST_ASD[6:0];
      pwmc <= RST_PWMC;
      steer <= RST_STEER;
      duty_high_byte <= RST_DUTY;
    end else if (wr_en) begin
      unique case (paddr[7:0])
        OFS_CTRL: ctrl <= pwdata[7:0];
        OFS_TSEL: tsel <= pwdata[7:0];
        OFS_ASD: asd <= pwdata[6:0];
        OFS_PWMC: pwmc <= pwdata[7:0];
        OFS_STEER: steer <= pwdata[4:0];
        OFS_DUTY: duty_high_byte <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Instruction cycle and steering update
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q_cnt <= 2'h0;
    end else begin
      q_cnt <= q_cnt + 2'h1;
    end
  end

  // Steering takes effect at period start or instruction edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      steer_eff <= RST_STEER[STR_HI:0];
    end else if (steer[SYNC_BIT] ? period_start : instr_edge) begin
      steer_eff <= steer[STR_HI:0];
    end
  end

  // ****************************************
  // Auto-shutdown
  // ****************************************
  assign src_hit = (shutdown_source[0] && cmp1_out)
                || (shutdown_source[1] && cmp2_out)
                || (shutdown_source[2] && !int_pin_n);

  // Status: source sets it, set wins over software or auto clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shutdown_status <= 1'b0;
    end else if (src_hit) begin
      shutdown_status <= 1'b1;
    end else if (wr_en && (paddr[7:0] == OFS_ASD)) begin
      shutdown_status <= pwdata[ASE_BIT];
    end else if (auto_restart_enable) begin
      shutdown_status <= 1'b0;
    end
  end

  // Outputs stay in shutdown until the period after release
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sd_state <= SD_RUN;
    end else if (mode_select == MODE_OFF) begin
      sd_state <= SD_RUN;
    end else begin
      unique case (sd_state)
        SD_RUN: if (shutdown_status) sd_state <= SD_TRIP;
        SD_TRIP: if (!shutdown_status) sd_state <= SD_RESUME;
        SD_RESUME: begin
          if (shutdown_status) begin
            sd_state <= SD_TRIP;
          end else if (period_start) begin
            sd_state <= SD_RUN;
          end
        end
        default: sd_state <= SD_TRIP;
      endcase
    end
  end

  // ****************************************
  // Dead-band delay, true and complement
  // ****************************************
  logic [DLY_W+1:0] dly_cnt [2];
  logic [1:0] dly_out;
  logic [DLY_W+1:0] dly_target;

  assign dly_target = {dead_delay_count, 2'b00};

  for (genvar ch = 0; ch < 2; ch++) begin : g_dly
    logic wave_in;
    assign wave_in = (ch == 0) ? pwm_raw : !pwm_raw;
    // Active edge waits the delay count in instruction cycles
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        dly_cnt[ch] <= '0;
        dly_out[ch] <= 1'b0;
      end else if (mode_select == MODE_OFF || !wave_in) begin
        dly_cnt[ch] <= '0;
        dly_out[ch] <= 1'b0;
      end else if (!dly_out[ch]) begin
        if (dly_cnt[ch] >= dly_target) begin
          dly_out[ch] <= 1'b1;
        end else begin
          dly_cnt[ch] <= dly_cnt[ch] + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Compare and capture
  // ****************************************
  logic mode_wr;
  logic cap_rise;
  logic cap_fall;
  logic cap_evt;
  logic cmp_irq;

  assign mode_wr = wr_en && (paddr[7:0] == OFS_CTRL) && (pwdata[3:0] != mode_select);
  assign cap_rise = cap_in && !cap_prev;
  assign cap_fall = !cap_in && cap_prev;
  assign cmp_irq = tmr_match && (mode_select[3:2] == 2'h2);

  // Capture edge choice with prescale
  always_comb begin
    cap_evt = 1'b0;
    unique case (mode_select)
      MODE_CAP_FALL: cap_evt = cap_fall;
      MODE_CAP_RISE: cap_evt = cap_rise;
      MODE_CAP_4: cap_evt = cap_rise && (presc[1:0] == PRESC_4_LAST[1:0]);
      MODE_CAP_16: cap_evt = cap_rise && (presc == PRESC_16_LAST);
      default: cap_evt = 1'b0;
    endcase
  end

  // Edge history and prescale counter
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_prev <= 1'b0;
      presc <= 4'h0;
    end else begin
      cap_prev <= cap_in;
      if (mode_select == MODE_OFF || mode_wr) begin
        presc <= 4'h0;
      end else if (cap_rise) begin
        presc <= presc + 4'h1;
      end
    end
  end

  // Compare pin state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_pin <= 1'b0;
    end else if (mode_wr) begin
      cmp_pin <= (pwdata[3:0] == MODE_CMP_CLR);
    end else if (mode_select == MODE_OFF) begin
      cmp_pin <= 1'b0;
    end else if (tmr_match) begin
      unique case (mode_select)
        MODE_TOGGLE: cmp_pin <= !cmp_pin;
        MODE_CMP_SET: cmp_pin <= 1'b1;
        MODE_CMP_CLR: cmp_pin <= 1'b0;
        default: ;
      endcase
    end
  end

  // Unit flag, event wins over write-one clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      unit_irq_flag <= 1'b0;
    end else if (cmp_irq || cap_evt) begin
      unit_irq_flag <= 1'b1;
    end else if (w1c_irq) begin
      unit_irq_flag <= 1'b0;
    end
  end

  // Event pulses and decoded values
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_pulse <= 1'b0;
      tmr_rst_pulse <= 1'b0;
      adc_start_pulse <= 1'b0;
      duty_value <= 10'h000;
      timer_pick <= 12'h000;
    end else begin
      cap_pulse <= cap_evt;
      tmr_rst_pulse <= tmr_match && (mode_select == MODE_CMP_SPECIAL);
      adc_start_pulse <= tmr_match && (mode_select == MODE_CMP_SPECIAL) && adc_enable;
      duty_value <= {duty_high_byte, ctrl[DCB_HI:DCB_LO]};
      for (int u = 0; u < 4; u++) begin
        timer_pick[3*u +: 3] <= (tsel[2*u +: 2] == TSEL_RESERVED) ? 3'h0
                              : 3'(3'h1 << tsel[2*u +: 2]);
      end
    end
  end

  // ****************************************
  // Pin decode
  // ****************************************
  logic [3:0] next_o;
  logic [3:0] next_oe_n;
  logic [3:0] next_port;

  always_comb begin
    next_o = 4'h0;
    next_oe_n = 4'hf;
    next_port = 4'hf;
    if (!is_pwm) begin
      // Pin A belongs to capture and to toggle/set/clear compare, others to port
      unique case (mode_select)
        MODE_TOGGLE, MODE_CMP_SET, MODE_CMP_CLR: begin
          next_port[PIN_A] = 1'b0;
          next_oe_n[PIN_A] = 1'b0;
          next_o[PIN_A] = cmp_pin;
        end
        MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_4, MODE_CAP_16: begin
          next_port[PIN_A] = 1'b0;
        end
        default: ;
      endcase
    end else begin
      unique case (output_config)
        CFG_SINGLE: begin
          for (int i = 0; i < 4; i++) begin
            if (steer_eff[i]) begin
              next_port[i] = 1'b0;
              next_oe_n[i] = 1'b0;
              next_o[i] = dly_out[0] ^ ((i % 2 == 0) ? pol_ac : pol_bd);
            end
          end
        end
        CFG_FWD: begin
          next_port = 4'h0;
          next_oe_n = 4'h0;
          next_o[PIN_A] = !pol_ac;
          next_o[PIN_B] = pol_bd;
          next_o[PIN_C] = pol_ac;
          next_o[PIN_D] = dly_out[0] ^ pol_bd;
        end
        CFG_HALF: begin
          next_port[PIN_A] = 1'b0;
          next_port[PIN_B] = 1'b0;
          next_oe_n[PIN_A] = 1'b0;
          next_oe_n[PIN_B] = 1'b0;
          next_o[PIN_A] = dly_out[0] ^ pol_ac;
          next_o[PIN_B] = dly_out[1] ^ pol_bd;
        end
        CFG_REV: begin
          next_port = 4'h0;
          next_oe_n = 4'h0;
          next_o[PIN_A] = pol_ac;
          next_o[PIN_B] = dly_out[0] ^ pol_bd;
          next_o[PIN_C] = !pol_ac;
          next_o[PIN_D] = pol_bd;
        end
      endcase
      if (sd_on) begin
        for (int i = 0; i < 4; i++) begin
          if (!next_port[i]) begin
            if ((i % 2 == 0) ? asd[PSSAC_HI] : asd[PSSBD_HI]) begin
              next_oe_n[i] = 1'b1;
              next_o[i] = 1'b0;
            end else begin
              next_oe_n[i] = 1'b0;
              next_o[i] = (i % 2 == 0) ? asd[PSSAC_LO] : asd[PSSBD_LO];
            end
          end
        end
      end
    end
  end

  // Registered pins
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_pin_o <= 4'h0;
      out_pin_oe_n <= 4'hf;
      out_pin_port <= 4'hf;
    end else begin
      out_pin_o <= next_o;
      out_pin_oe_n <= next_oe_n;
      out_pin_port <= next_port;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_nonpwm_port: assert property (@(posedge mclk) disable iff (sys_rst)
    !is_pwm |=> out_pin_port[3:1] == 3'h7)
    else $error("non-PWM mode left B, C or D off the port");

  a_rev_pins: assert property (@(posedge mclk) disable iff (sys_rst)
    (is_pwm && output_config == CFG_REV && !sd_on)
    |=> (out_pin_o[PIN_C] == !$past(pol_ac)) && (out_pin_oe_n == 4'h0))
    else $error("reverse bridge pins wrong");

  a_toggle_match: assert property (@(posedge mclk) disable iff (sys_rst)
    (mode_select == MODE_TOGGLE && tmr_match && !mode_wr) |=> cmp_pin != $past(cmp_pin))
    else $error("compare pin did not toggle on match");

  a_flag_on_match: assert property (@(posedge mclk) disable iff (sys_rst)
    (tmr_match && mode_select == MODE_CMP_SET) |=> unit_irq_flag ##1 1)
    else $error("match did not set the unit flag");

  a_special_event: assert property (@(posedge mclk) disable iff (sys_rst)
    (tmr_match && mode_select == MODE_CMP_SPECIAL && adc_enable)
    |=> tmr_rst_pulse && adc_start_pulse)
    else $error("special event missed timer reset or conversion");

  a_sd_status_set: assert property (@(posedge mclk) disable iff (sys_rst)
    src_hit |=> shutdown_status ##1 sd_on)
    else $error("shutdown source did not trip the outputs");

  a_resume_period: assert property (@(posedge mclk) disable iff (sys_rst)
    (sd_state == SD_RESUME && !period_start && !shutdown_status
     && mode_select != MODE_OFF) |=> sd_on)
    else $error("outputs resumed before a period start");

  a_dead_delay: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(dly_out[0]) |-> $past(dly_cnt[0]) >= $past(dly_target))
    else $error("active edge came before the dead delay");

  a_steer_update: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(steer_eff) |-> ($past(steer[SYNC_BIT]) ? $past(period_start)
                                                    : $past(instr_edge)))
    else $error("steering changed outside its update point");

  a_duty_join: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 duty_value == {$past(duty_high_byte), $past(ctrl[DCB_HI:DCB_LO])})
    else $error("duty value not joined from high byte and low bits");

endmodule : eccp_ctrl_decode

`default_nettype wire

// File: sim/eccp_bridge_model.sv
// Bridge power-switch model: the gate level that each switch sees
`timescale 1ns/1ps
`default_nettype none

module eccp_bridge_model (
  // Pin drive from the block
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe_n,
  input wire logic [3:0] pin_port,
  // Gate level seen at each switch
  output logic [3:0] gate_lvl
);
  // Released or port-held pins fall to the gate pull-down, switch off
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gate_lvl[i] = (pin_oe_n[i] || pin_port[i]) ? 1'b0 : pin_o[i];
    end
  end
endmodule : eccp_bridge_model

`default_nettype wire

// File: sim/testbench.sv
// Register and pin level testbench for the capture/compare/PWM control block
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
  import eccp_pkg::*;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic tmr_match, period_start, pwm_raw, cap_in, cmp1_out, cmp2_out, int_pin_n;
  logic adc_enable, cap_pulse, tmr_rst_pulse, adc_start_pulse;
  bit seen_rst, seen_adc;
  logic [9:0] duty_value;
  logic [11:0] timer_pick;
  logic [3:0] pin_o, pin_oe_n, pin_port, lvl;
  int miscompares, checks_done, cyc, ncap, nbase;
  logic [7:0] cfg [5] = '{8'h0c, 8'h4c, 8'h8c, 8'hcc, 8'hcf};
  logic [7:0] pexp [5] = '{8'he1, 8'h09, 8'hc1, 8'h06, 8'h09};
  int cexp [4] = '{4, 4, 1, 1};

  // ****************************************
  // Design, bridge model, clock
  // ****************************************
  eccp_ctrl_decode dut_u (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tmr_match(tmr_match), .period_start(period_start),
    .pwm_raw(pwm_raw), .cap_in(cap_in), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
    .int_pin_n(int_pin_n), .adc_enable(adc_enable), .cap_pulse(cap_pulse),
    .tmr_rst_pulse(tmr_rst_pulse), .adc_start_pulse(adc_start_pulse),
    .duty_value(duty_value), .timer_pick(timer_pick), .out_pin_o(pin_o),
    .out_pin_oe_n(pin_oe_n), .out_pin_port(pin_port));
  eccp_bridge_model bridge_u (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_port(pin_port),
    .gate_lvl(lvl));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Period pulses, event monitors, hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    period_start <= (cyc % 16 == 15);
    if (cap_pulse === 1'b1) ncap <= ncap + 1;
    if (tmr_rst_pulse === 1'b1) seen_rst <= 1'b1;
    if (adc_start_pulse === 1'b1) seen_adc <= 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask : w

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask : rd

  task automatic pulse_match();
    tmr_match <= 1'b1;
    @(posedge mclk);
    tmr_match <= 1'b0;
    w(4);
  endtask : pulse_match

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {sys_rst, psel, penable, pwrite, tmr_match, pwm_raw, cap_in} = 7'h40;
    {cmp1_out, cmp2_out, adc_enable} = 3'h0;
    int_pin_n = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    w(6);
    sys_rst <= 1'b0;
    @(posedge mclk);
    `CHK(pin_port, 4'hf)
    for (int i = 0; i < 6; i++) rd(8'(i * 4), {31'h0, i == 4});
    apb(1'b0, 8'h1c, 32'h0);
    `CHK({err, rdat}, 33'h100000000)
    apb(1'b1, OFS_TSEL, 32'he4);
    apb(1'b1, OFS_DUTY, 32'ha5);
    apb(1'b1, OFS_CTRL, 32'h3c);
    w(3);
    `CHK(timer_pick, 12'h111)
    `CHK(duty_value, 10'h297)
    apb(1'b1, OFS_CTRL, 32'h08);
    w(2);
    `CHK({pin_oe_n[0], pin_o[0]}, 2'b00)
    pulse_match();
    `CHK(pin_o[0], 1'b1)
    apb(1'b1, OFS_CTRL, 32'h09);
    w(2);
    `CHK(pin_o[0], 1'b1)
    pulse_match();
    `CHK(pin_o[0], 1'b0)
    rd(OFS_STAT, 32'h1);
    apb(1'b1, OFS_STAT, 32'h1);
    rd(OFS_STAT, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h02);
    pulse_match();
    `CHK(pin_o[0], 1'b1)
    apb(1'b1, OFS_CTRL, 32'h0a);
    pulse_match();
    rd(OFS_STAT, 32'h1);
    `CHK(pin_port, 4'hf)
    adc_enable <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h0b);
    pulse_match();
    `CHK({seen_rst, seen_adc, pin_port}, 6'h3f)
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFS_CTRL, 32'h04 + m);
      nbase = ncap;
      repeat ((m == 3) ? 16 : 4) begin
        cap_in <= 1'b1;
        w(3);
        cap_in <= 1'b0;
        w(3);
      end
      `CHK(ncap - nbase, cexp[m])
    end
    pwm_raw <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFS_CTRL, {24'h0, cfg[i]});
      w(40);
      `CHK({pin_port, lvl}, pexp[i])
    end
    // Half bridge: complement edge waits one instruction cycle plus one
    apb(1'b1, OFS_PWMC, 32'h01);
    apb(1'b1, OFS_CTRL, 32'h8c);
    w(10);
    pwm_raw <= 1'b0;
    w(5);
    `CHK(lvl[1:0], 2'b00)
    w(2);
    `CHK(lvl[1:0], 2'b10)
    pwm_raw <= 1'b1;
    apb(1'b1, OFS_STEER, 32'h0c);
    apb(1'b1, OFS_CTRL, 32'h0d);
    w(40);
    `CHK({pin_port, lvl}, 8'h34)
    // Synced steering waits for the period pulse eleven cycles after the write
    while (cyc % 16 != 2) @(posedge mclk);
    apb(1'b1, OFS_STEER, 32'h13);
    w(6);
    `CHK(pin_port, 4'h3)
    w(8);
    `CHK(pin_port, 4'hc)
    apb(1'b1, OFS_CTRL, 32'h4c);
    apb(1'b1, OFS_ASD, 32'h16);
    cmp1_out <= 1'b1;
    w(5);
    `CHK({pin_oe_n, lvl}, 8'ha5)
    cmp1_out <= 1'b0;
    w(40);
    rd(OFS_ASD, 32'h96);
    apb(1'b1, OFS_ASD, 32'h16);
    w(40);
    `CHK({pin_oe_n, lvl}, 8'h09)
    apb(1'b1, OFS_PWMC, 32'h80);
    apb(1'b1, OFS_ASD, 32'h66);
    int_pin_n <= 1'b0;
    w(5);
    rd(OFS_ASD, 32'he6);
    int_pin_n <= 1'b1;
    w(40);
    rd(OFS_ASD, 32'h66);
    cmp2_out <= 1'b1;
    w(5);
    rd(OFS_ASD, 32'he6);
    cmp2_out <= 1'b0;
    w(40);
    rd(OFS_ASD, 32'h66);
    `CHK({pin_oe_n, lvl}, 8'h09)
    finish_test();
  end
endmodule : testbench

`default_nettype wire
